// File: logic/fid_cmd_top.sv
// serial flash identity, deep power-down and security register read commands
// How it works
// - 92h dual address, bit0 picks byte order
// - 94h quad address, four dummies, same order
// - 9Fh gives maker, type, capacity bytes
// - 9Fh ignored while a cycle runs
// - output on falling clock; deselect ends command
// - 4Bh, 32 dummy clocks, 64-bit number out
// - B9h only if deselected right after opcode
// - sleep reached within entry time
// - asleep: only ABh recognised
// - power-up always awake and idle
// - ABh then deselect wakes after plain delay
// - ABh plus dummies repeats device identity
// - ABh ignored while awake and write in progress
// - 48h address, dummy byte, then data out
// - security byte address wraps at FFh
// - security address decode selects register
// - write-in-progress flag follows running cycle
`timescale 1ns/100ps
`include "fid_regs.svh"
module fid_cmd_top #(
   parameter logic [7:0]  MFR_ID          = 8'h5a,                  // arbitrary value
   parameter logic [7:0]  DEV_ID          = 8'h17,                  // arbitrary value
   parameter logic [7:0]  TYPE_ID         = 8'h40,                  // arbitrary value
   parameter logic [7:0]  CAP_ID          = 8'h18,                  // arbitrary value
   parameter logic [63:0] UNIQUE_ID       = 64'h0123_4567_89ab_cdef, // arbitrary value
   parameter int          SLEEP_ENTRY_CYC = `FID_SLEEP_ENTRY_CYC,
   parameter int          WAKE_PLAIN_CYC  = `FID_WAKE_PLAIN_CYC,
   parameter int          WAKE_IDENT_CYC  = `FID_WAKE_IDENT_CYC
) (
   input  wire logic       i_clock,
   input  wire logic       i_resetn,
   input  wire logic       i_spi_cs_n,
   input  wire logic       i_spi_clock,
   input  wire logic [3:0] i_spi_io,
   output logic      [3:0] o_spi_io,
   output logic      [3:0] o_spi_io_oe,
   input  wire logic       i_cycle_busy,
   output logic            o_write_in_progress,
   output logic            o_deep_sleep,
   input  wire logic       i_sec_wr_en,
   input  wire logic [9:0] i_sec_wr_addr,
   input  wire logic [7:0] i_sec_wr_data
);

   fid_pkg::fid_state_t s;
   fid_pkg::fid_state_t n;

   logic       rise;
   logic       fall;
   logic       cs_up;
   logic       opc_done;
   logic [7:0] opcode_in;
   logic       sec_ok;
   logic [3:0] sel_m1;
   logic [2:0] idx_adv;

   fid_sec_if sec ();

   fid_secreg_store u_store (
      .i_clock (i_clock),
      .bus     (sec)
   );

   assign rise      = s.s2_sck & ~s.sck_prev;
   assign fall      = ~s.s2_sck & s.sck_prev;
   assign cs_up     = s.s2_cs_n & ~s.cs_prev;
   assign opcode_in = {s.opcode[6:0], s.s2_io[0]};
   assign opc_done  = rise & ~s.s2_cs_n & (s.st == fid_pkg::FID_CMD_OPCODE) & (s.cnt == `FID_OPCODE_LAST_BIT);

   // register select and byte decode
   assign sel_m1 = s.addr[15:12] - 4'h1;
   assign sec_ok = (s.addr[23:16] == `FID_SEC_HI) && (s.addr[11:8] == `FID_SEC_MID) &&
                   (s.addr[15:12] >= `FID_SEC_SEL_FIRST) && (s.addr[15:12] <= `FID_SEC_SEL_LAST);
   assign sec.rd_addr = {sel_m1[1:0], s.ptr};
   assign sec.wr_en   = i_sec_wr_en;
   assign sec.wr_addr = i_sec_wr_addr;
   assign sec.wr_data = i_sec_wr_data;

   assign idx_adv = ((s.opcode == `FID_OP_ID_STD) && (s.idx == 3'h2)) ? 3'h0 : s.idx + 3'h1;

   function automatic logic [7:0] pick_byte(input logic [7:0] op, input logic [2:0] idx, input logic a0,
                                            input logic ok, input logic [7:0] data);
      logic [7:0] b;
      b = DEV_ID;
      case (op)
         `FID_OP_ID_DUAL, `FID_OP_ID_QUAD: b = (idx[0] ^ a0) ? DEV_ID : MFR_ID;
         `FID_OP_ID_STD: b = (idx == 3'h0) ? MFR_ID : ((idx == 3'h1) ? TYPE_ID : CAP_ID);
         `FID_OP_UID:    b = UNIQUE_ID[{~idx, 3'b000} +: 8];
         `FID_OP_SECREG: b = ok ? data : `FID_SEC_BLANK;
         default:        b = DEV_ID;
      endcase
      return b;
   endfunction : pick_byte

   always_comb begin
      logic go_out;
      go_out    = 1'b0;
      n         = s;
      n.s1_cs_n = i_spi_cs_n;
      n.s2_cs_n = s.s1_cs_n;
      n.cs_prev = s.s2_cs_n;
      n.s1_sck  = i_spi_clock;
      n.s2_sck  = s.s1_sck;
      n.sck_prev = s.s2_sck;
      n.s1_io   = i_spi_io;
      n.s2_io   = s.s1_io;
      n.write_in_progress     = i_cycle_busy;

      unique case (s.pwr)
         fid_pkg::FID_PWR_AWAKE, fid_pkg::FID_PWR_ASLEEP: begin
         end
         fid_pkg::FID_PWR_ENTERING: begin
            if (s.timer == 12'h000) begin
               n.pwr = fid_pkg::FID_PWR_ASLEEP;
            end else begin
               n.timer = s.timer - 12'h001;
            end
         end
         fid_pkg::FID_PWR_WAKING: begin
            if (s.timer == 12'h000) begin
               n.pwr = fid_pkg::FID_PWR_AWAKE;
            end else begin
               n.timer = s.timer - 12'h001;
            end
         end
      endcase

      if (s.s2_cs_n) begin
         // deselected: back to standby, output released
         n.st  = fid_pkg::FID_CMD_OPCODE;
         n.cnt = 6'h00;
         n.oe  = 4'h0;
         if (cs_up) begin
            n.wake_armed = 1'b0;
            if ((s.st == fid_pkg::FID_CMD_HOLD) && (s.opcode == `FID_OP_SLEEP) &&
                (s.pwr == fid_pkg::FID_PWR_AWAKE)) begin
               n.pwr   = fid_pkg::FID_PWR_ENTERING;
               n.timer = 12'(SLEEP_ENTRY_CYC - 1);
            end else if (s.wake_armed) begin
               n.pwr = fid_pkg::FID_PWR_WAKING;
               if (s.st == fid_pkg::FID_CMD_HOLD) begin
                  n.timer = 12'(WAKE_PLAIN_CYC - 1);
               end else begin
                  n.timer = 12'(WAKE_IDENT_CYC - 1);
               end
            end
         end
      end else if (rise) begin
         // inputs latched on rising clock
         unique case (s.st)
            fid_pkg::FID_CMD_OPCODE: begin
               n.opcode = opcode_in;
               n.cnt    = s.cnt + 6'h01;
               if (opc_done) begin
                  n.cnt        = 6'h00;
                  n.lanes      = `FID_LANES_SINGLE;
                  n.dummy_clks = `FID_DUMMY_NONE;
                  n.addr_clks  = `FID_ADDR_CLKS_SINGLE;
                  if (s.pwr == fid_pkg::FID_PWR_ASLEEP) begin
                     if (opcode_in == `FID_OP_WAKE) begin
                        n.st         = fid_pkg::FID_CMD_HOLD;
                        n.wake_armed = 1'b1;
                     end else begin
                        n.st = fid_pkg::FID_CMD_IGNORE;
                     end
                  end else if (s.pwr != fid_pkg::FID_PWR_AWAKE) begin
                     n.st = fid_pkg::FID_CMD_IGNORE;
                  end else begin
                     case (opcode_in)
                        `FID_OP_ID_DUAL: begin
                           n.lanes     = `FID_LANES_DUAL;
                           n.addr_clks = `FID_ADDR_CLKS_DUAL;
                           n.st        = fid_pkg::FID_CMD_ADDR;
                        end
                        `FID_OP_ID_QUAD: begin
                           n.lanes      = `FID_LANES_QUAD;
                           n.addr_clks  = `FID_ADDR_CLKS_QUAD;
                           n.dummy_clks = `FID_DUMMY_QUAD;
                           n.st         = fid_pkg::FID_CMD_ADDR;
                        end
                        `FID_OP_ID_STD: begin
                           if (s.write_in_progress) begin
                              n.st = fid_pkg::FID_CMD_IGNORE;
                           end else begin
                              go_out = 1'b1;
                           end
                        end
                        `FID_OP_UID: begin
                           n.dummy_clks = `FID_DUMMY_UID;
                           n.st         = fid_pkg::FID_CMD_DUMMY;
                        end
                        `FID_OP_SLEEP: begin
                           n.st = fid_pkg::FID_CMD_HOLD;
                        end
                        `FID_OP_WAKE: begin
                           n.st = s.write_in_progress ? fid_pkg::FID_CMD_IGNORE : fid_pkg::FID_CMD_HOLD;
                        end
                        `FID_OP_SECREG: begin
                           n.dummy_clks = `FID_DUMMY_SECREG;
                           n.st         = fid_pkg::FID_CMD_ADDR;
                        end
                        default: begin
                           n.st = fid_pkg::FID_CMD_IGNORE;
                        end
                     endcase
                  end
               end
            end
            fid_pkg::FID_CMD_ADDR: begin
               case (s.lanes)
                  `FID_LANES_DUAL: n.addr = {s.addr[21:0], s.s2_io[1:0]};
                  `FID_LANES_QUAD: n.addr = {s.addr[19:0], s.s2_io[3:0]};
                  default:         n.addr = {s.addr[22:0], s.s2_io[0]};
               endcase
               n.cnt = s.cnt + 6'h01;
               if (s.cnt == (s.addr_clks - 6'h01)) begin
                  n.cnt = 6'h00;
                  n.ptr = n.addr[7:0];
                  if (s.dummy_clks == `FID_DUMMY_NONE) begin
                     go_out = 1'b1;
                  end else begin
                     n.st = fid_pkg::FID_CMD_DUMMY;
                  end
               end
            end
            fid_pkg::FID_CMD_DUMMY: begin
               n.cnt = s.cnt + 6'h01;
               if (s.cnt == (s.dummy_clks - 6'h01)) begin
                  go_out = 1'b1;
               end
            end
            fid_pkg::FID_CMD_HOLD: begin
               // any further clock after the opcode
               if (s.opcode == `FID_OP_WAKE) begin
                  n.st         = fid_pkg::FID_CMD_DUMMY;
                  n.dummy_clks = `FID_DUMMY_WAKE;
                  n.cnt        = 6'h01;
               end else begin
                  n.st = fid_pkg::FID_CMD_IGNORE;
               end
            end
            fid_pkg::FID_CMD_OUT, fid_pkg::FID_CMD_IGNORE: begin
            end
            default: begin
               n.st = fid_pkg::FID_CMD_IGNORE;
            end
         endcase
      end else if (fall && (s.st == fid_pkg::FID_CMD_OUT)) begin
         // output lanes change on falling clock only
         case (s.lanes)
            `FID_LANES_DUAL: begin
               n.dout = {2'b00, s.ob[7:6]};
               n.oe   = `FID_OE_DUAL;
            end
            `FID_LANES_QUAD: begin
               n.dout = s.ob[7:4];
               n.oe   = `FID_OE_QUAD;
            end
            default: begin
               n.dout = {2'b00, s.ob[7], 1'b0};
               n.oe   = `FID_OE_SINGLE;
            end
         endcase
         if (s.left == {1'b0, s.lanes}) begin
            n.ob   = pick_byte(s.opcode, s.idx, s.addr[0], sec_ok, sec.rd_data);
            n.idx  = idx_adv;
            n.ptr  = s.ptr + 8'h01;
            n.left = `FID_BYTE_BITS;
         end else begin
            n.ob   = s.ob << s.lanes;
            n.left = s.left - {1'b0, s.lanes};
         end
      end

      if (go_out) begin
         n.st   = fid_pkg::FID_CMD_OUT;
         n.ob   = pick_byte(n.opcode, 3'h0, n.addr[0], sec_ok, sec.rd_data);
         n.idx  = 3'h1;
         n.ptr  = s.ptr + 8'h01;
         n.left = `FID_BYTE_BITS;
      end
   end

   always_ff @(posedge i_clock or negedge i_resetn) begin
      if (!i_resetn) begin
         s         <= '0;
         s.s1_cs_n <= 1'b1;
         s.s2_cs_n <= 1'b1;
         s.cs_prev <= 1'b1;
         s.lanes   <= `FID_LANES_SINGLE;
      end else begin
         s <= n;
      end
   end

   assign o_spi_io            = s.dout;
   assign o_spi_io_oe         = s.oe;
   assign o_write_in_progress = s.write_in_progress;
   assign o_deep_sleep        = (s.pwr == fid_pkg::FID_PWR_ASLEEP);

   localparam int ENTRY_MAX = SLEEP_ENTRY_CYC + 1;
   localparam int PLAIN_MAX = WAKE_PLAIN_CYC + 1;
   localparam int IDENT_MAX = WAKE_IDENT_CYC + 1;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);

   sequence sleep_entry_s;
      (s.pwr == fid_pkg::FID_PWR_ENTERING) ##[1:ENTRY_MAX] (s.pwr == fid_pkg::FID_PWR_ASLEEP);
   endsequence
   sequence wake_plain_s;
      (s.pwr == fid_pkg::FID_PWR_WAKING) ##[1:PLAIN_MAX] (s.pwr == fid_pkg::FID_PWR_AWAKE);
   endsequence
   sequence wake_ident_s;
      (s.pwr == fid_pkg::FID_PWR_WAKING) ##[1:IDENT_MAX] (s.pwr == fid_pkg::FID_PWR_AWAKE);
   endsequence

   sleep_entry_a: assert property (
      cs_up && (s.st == fid_pkg::FID_CMD_HOLD) && (s.opcode == `FID_OP_SLEEP) &&
      (s.pwr == fid_pkg::FID_PWR_AWAKE) |=> sleep_entry_s)
      else $error("deep sleep not reached in time");
   sleep_cancel_a: assert property (
      rise && !s.s2_cs_n && (s.st == fid_pkg::FID_CMD_HOLD) && (s.opcode == `FID_OP_SLEEP)
      |=> (s.st == fid_pkg::FID_CMD_IGNORE) && (s.pwr != fid_pkg::FID_PWR_ENTERING))
      else $error("late clock did not cancel sleep");
   sleep_filter_a: assert property (
      opc_done && (s.pwr == fid_pkg::FID_PWR_ASLEEP) && (opcode_in != `FID_OP_WAKE)
      |=> (s.st == fid_pkg::FID_CMD_IGNORE))
      else $error("opcode accepted while asleep");
   wake_plain_a: assert property (
      cs_up && s.wake_armed && (s.st == fid_pkg::FID_CMD_HOLD) |=> wake_plain_s)
      else $error("plain wake delay wrong");
   wake_ident_a: assert property (
      cs_up && s.wake_armed && (s.st != fid_pkg::FID_CMD_HOLD) |=> wake_ident_s)
      else $error("identity wake delay wrong");
   busy_std_a: assert property (
      opc_done && (opcode_in == `FID_OP_ID_STD) && s.write_in_progress |=> (s.st == fid_pkg::FID_CMD_IGNORE))
      else $error("identity read decoded while busy");
   busy_release_a: assert property (
      opc_done && (opcode_in == `FID_OP_WAKE) && s.write_in_progress && (s.pwr == fid_pkg::FID_PWR_AWAKE)
      |=> (s.st == fid_pkg::FID_CMD_IGNORE))
      else $error("release decoded while busy");
   ignore_quiet_a: assert property (
      (s.st == fid_pkg::FID_CMD_IGNORE) |-> (o_spi_io_oe == 4'h0))
      else $error("output driven for ignored opcode");
   fall_edge_a: assert property (
      $changed(o_spi_io) |-> $past(fall))
      else $error("output changed without falling clock");
   deselect_a: assert property (
      s.s2_cs_n |=> (o_spi_io_oe == 4'h0) && (s.st == fid_pkg::FID_CMD_OPCODE))
      else $error("deselect did not end command");
   sec_wrap_a: assert property (
      fall && (s.st == fid_pkg::FID_CMD_OUT) && (s.opcode == `FID_OP_SECREG) &&
      (s.left == {1'b0, s.lanes}) && (s.ptr == 8'hff) |=> (s.ptr == 8'h00))
      else $error("security byte address did not wrap");
   powerup_a: assert property (
      $rose(i_resetn) |-> (s.pwr == fid_pkg::FID_PWR_AWAKE) && (o_spi_io_oe == 4'h0))
      else $error("not awake after reset");

endmodule : fid_cmd_top

// File: logic/fid_regs.svh
// opcode, field and timing constants of the identity and power-down command block
`ifndef FID_REGS_SVH
`define FID_REGS_SVH

`define FID_OP_ID_DUAL        8'h92
`define FID_OP_ID_QUAD        8'h94
`define FID_OP_ID_STD         8'h9f
`define FID_OP_UID            8'h4b
`define FID_OP_SLEEP          8'hb9
`define FID_OP_WAKE           8'hab
`define FID_OP_SECREG         8'h48

`define FID_OPCODE_LAST_BIT   6'h07
`define FID_ADDR_CLKS_SINGLE  6'h18
`define FID_ADDR_CLKS_DUAL    6'h0c
`define FID_ADDR_CLKS_QUAD    6'h06
`define FID_DUMMY_NONE        6'h00
`define FID_DUMMY_QUAD        6'h04
`define FID_DUMMY_UID         6'h20
`define FID_DUMMY_WAKE        6'h18
`define FID_DUMMY_SECREG      6'h08

`define FID_LANES_SINGLE      3'h1
`define FID_LANES_DUAL        3'h2
`define FID_LANES_QUAD        3'h4
`define FID_BYTE_BITS         4'h8
`define FID_OE_SINGLE         4'h2
`define FID_OE_DUAL           4'h3
`define FID_OE_QUAD           4'hf

`define FID_SEC_HI            8'h00
`define FID_SEC_MID           4'h0
`define FID_SEC_SEL_FIRST     4'h1
`define FID_SEC_SEL_LAST      4'h3
`define FID_SEC_BLANK         8'hff
`define FID_SEC_DEPTH         768

`define FID_CLK_MHZ           40
`define FID_SLEEP_ENTRY_NS    3000
`define FID_WAKE_PLAIN_NS     8000
`define FID_WAKE_IDENT_NS     8000
`define FID_SLEEP_ENTRY_CYC   ((`FID_SLEEP_ENTRY_NS * `FID_CLK_MHZ) / 1000)
`define FID_WAKE_PLAIN_CYC    ((`FID_WAKE_PLAIN_NS * `FID_CLK_MHZ) / 1000)
`define FID_WAKE_IDENT_CYC    ((`FID_WAKE_IDENT_NS * `FID_CLK_MHZ) / 1000)

`endif

// File: logic/fid_pkg.sv
// types of the identity and power-down command block
package fid_pkg;

   typedef enum logic [2:0] {
      FID_CMD_OPCODE = 3'h0,
      FID_CMD_ADDR   = 3'h1,
      FID_CMD_DUMMY  = 3'h3,
      FID_CMD_OUT    = 3'h2,
      FID_CMD_HOLD   = 3'h6,
      FID_CMD_IGNORE = 3'h4
   } fid_cmd_t;

   typedef enum logic [1:0] {
      FID_PWR_AWAKE    = 2'h0,
      FID_PWR_ENTERING = 2'h1,
      FID_PWR_ASLEEP   = 2'h3,
      FID_PWR_WAKING   = 2'h2
   } fid_pwr_t;

   typedef struct packed {
      logic        s1_cs_n;
      logic        s2_cs_n;
      logic        cs_prev;
      logic        s1_sck;
      logic        s2_sck;
      logic        sck_prev;
      logic [3:0]  s1_io;
      logic [3:0]  s2_io;
      logic        write_in_progress;
      fid_pwr_t    pwr;
      logic [11:0] timer;
      logic        wake_armed;
      fid_cmd_t    st;
      logic [7:0]  opcode;
      logic [5:0]  cnt;
      logic [5:0]  addr_clks;
      logic [5:0]  dummy_clks;
      logic [2:0]  lanes;
      logic [23:0] addr;
      logic [7:0]  ptr;
      logic [2:0]  idx;
      logic [7:0]  ob;
      logic [3:0]  left;
      logic [3:0]  dout;
      logic [3:0]  oe;
   } fid_state_t;

endpackage : fid_pkg

// File: logic/fid_sec_if.sv
// security register storage port between command logic and byte store
`timescale 1ns/100ps
interface fid_sec_if;
   logic [9:0] rd_addr;
   logic [7:0] rd_data;
   logic       wr_en;
   logic [9:0] wr_addr;
   logic [7:0] wr_data;

   modport user  (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
   modport store (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : fid_sec_if

// File: logic/fid_secreg_store.sv
// three 256-byte security registers as one byte array
`timescale 1ns/100ps
`include "fid_regs.svh"
module fid_secreg_store (
   input  wire logic i_clock,
   fid_sec_if.store  bus
);

   logic [7:0] mem [0:`FID_SEC_DEPTH-1];

   always_ff @(posedge i_clock) begin
      if (bus.wr_en) begin
         mem[bus.wr_addr] <= bus.wr_data;
      end
   end

   assign bus.rd_data = mem[bus.rd_addr];

endmodule : fid_secreg_store

// File: sim/fid_host_model.sv
// host serial controller model: select, serial clock and lanes
`timescale 1ns/100ps
module fid_host_model (
   output logic            o_cs_n,
   output logic            o_sck,
   output logic      [3:0] o_io,
   input  wire logic [3:0] i_io,
   input  wire logic [3:0] i_oe
);
   localparam realtime HALF = 100.0;

   initial begin
      o_cs_n = 1'b1;
      o_sck  = 1'b0;
      o_io   = 4'h5;
   end

   // one frame; clock stands still outside it, released lanes toggle each clock
   task automatic frame(input logic [7:0] op, input logic [23:0] adr, input int aclk, input int alanes,
                        input int dum, input int oclk, input int olanes,
                        output logic [63:0] rd, output logic [3:0] oe_seen);
      int         k;
      int         j;
      logic [3:0] v;
      rd      = 64'h0;
      oe_seen = 4'h0;
      // changes land on falling system clock edges, between rising ones
      #(HALF / 8);
      o_cs_n  = 1'b0;
      #(HALF);
      for (k = 0; k < 8 + aclk + dum + oclk; k++) begin
         v = ~o_io;
         if (k < 8) begin
            v[0] = op[7 - k];
         end else if (k < 8 + aclk) begin
            for (j = 0; j < alanes; j++) begin
               v[alanes - 1 - j] = adr[23 - j];
            end
            adr = adr << alanes;
         end
         o_io = v;
         #(HALF);
         o_sck   = 1'b1;
         oe_seen = oe_seen | i_oe;
         if (k >= 8 + aclk + dum) begin
            if (olanes == 1) begin
               rd = {rd[62:0], i_io[1]};
            end else begin
               for (j = olanes - 1; j >= 0; j--) begin
                  rd = {rd[62:0], i_io[j]};
               end
            end
         end
         #(HALF);
         o_sck = 1'b0;
      end
      #(HALF / 2);
      o_cs_n = 1'b1;
      #(2 * HALF - HALF / 8);
   endtask : frame
endmodule : fid_host_model

// File: sim/tb_flash_id_powerdown_secreg_cmds.sv
// self-checking bench of the identity, power-down and security register commands
`timescale 1ns/100ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
   $display("unexpected at %0t got %h exp %h", $time, (got), (exp)); end end
module tb_flash_id_powerdown_secreg_cmds;
   localparam logic [7:0]  MFR  = 8'h3c;                 // arbitrary value
   localparam logic [7:0]  DEV  = 8'h71;                 // arbitrary value
   localparam logic [7:0]  TYP  = 8'h22;                 // arbitrary value
   localparam logic [7:0]  CAP  = 8'h19;                 // arbitrary value
   localparam logic [63:0] UID  = 64'hfeed_0bad_1234_5678; // arbitrary value
   localparam int          SLP  = 8;
   localparam int          WK1  = 16;
   localparam int          WK2  = 24;
   logic        i_clock;
   logic        resetn;
   logic        busy;
   logic        wr_en;
   logic [9:0]  wr_addr;
   logic [7:0]  wr_data;
   logic        cs_n;
   logic        sck;
   logic [3:0]  host_io;
   logic [3:0]  dev_io;
   logic [3:0]  dev_oe;
   logic [3:0]  spi_io;
   logic        write_in_progress;
   logic        sleep;
   logic [63:0] rd;
   logic [3:0]  oe;
   logic [15:0] lfsr;
   logic [7:0]  b;
   logic [7:0]  mem [768];
   int          failures;
   int          cmp_count;
   int          cycles;
   int          i;

   assign spi_io = (dev_oe & dev_io) | (~dev_oe & host_io);

   fid_cmd_top #(.MFR_ID(MFR), .DEV_ID(DEV), .TYPE_ID(TYP), .CAP_ID(CAP), .UNIQUE_ID(UID),
      .SLEEP_ENTRY_CYC(SLP), .WAKE_PLAIN_CYC(WK1), .WAKE_IDENT_CYC(WK2)) i_dut (
      .i_clock(i_clock), .i_resetn(resetn), .i_spi_cs_n(cs_n), .i_spi_clock(sck), .i_spi_io(spi_io),
      .o_spi_io(dev_io), .o_spi_io_oe(dev_oe), .i_cycle_busy(busy), .o_write_in_progress(write_in_progress),
      .o_deep_sleep(sleep), .i_sec_wr_en(wr_en), .i_sec_wr_addr(wr_addr), .i_sec_wr_data(wr_data));

   fid_host_model i_host (.o_cs_n(cs_n), .o_sck(sck), .o_io(host_io), .i_io(spi_io), .i_oe(dev_oe));

   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next

   function automatic logic [31:0] id_order(input logic a0);
      return a0 ? {DEV, MFR, DEV, MFR} : {MFR, DEV, MFR, DEV};
   endfunction : id_order

   task automatic sec_write(input logic [9:0] a, input logic [7:0] d);
      @(posedge i_clock);
      wr_en   <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      mem[a] = d;
      @(posedge i_clock);
      wr_en <= 1'b0;
   endtask : sec_write

   task automatic done(input string name);
      $display("test %s done", name);
   endtask : done

   task automatic results;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : results

   initial begin
      i_clock = 1'b0;
      forever #12.5 i_clock = ~i_clock;
   end

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 40000) begin
         failures++;
         results();
      end
   end

   initial begin
      {resetn, busy, wr_en, wr_addr, wr_data} = '0;
      {failures, cmp_count, cycles} = '0;
      lfsr = 16'h0001;
      repeat (10) @(posedge i_clock);
      `CHK(dev_oe, 4'h0)
      resetn <= 1'b1;
      repeat (4) @(posedge i_clock);
      `CHK(sleep, 1'b0)
      i_host.frame(8'h9f, 24'h0, 0, 1, 0, 48, 1, rd, oe);
      `CHK(rd[47:0], {MFR, TYP, CAP, MFR, TYP, CAP})
      `CHK(oe, 4'h2)
      for (i = 0; i < 2; i++) begin
         i_host.frame(8'h92, {23'h0, i[0]}, 12, 2, 0, 16, 2, rd, oe);
         `CHK(rd[31:0], id_order(i[0]))
         `CHK(oe, 4'h3)
         i_host.frame(8'h94, {23'h0, i[0]}, 6, 4, 4, 8, 4, rd, oe);
         `CHK(rd[31:0], id_order(i[0]))
         `CHK(oe, 4'hf)
      end
      i_host.frame(8'h4b, 24'h0, 0, 1, 32, 64, 1, rd, oe);
      `CHK(rd, UID)
      i_host.frame(8'hab, 24'h0, 0, 1, 24, 16, 1, rd, oe);
      `CHK(rd[15:0], {DEV, DEV})
      i_host.frame(8'h00, 24'h0, 0, 1, 0, 16, 1, rd, oe);
      `CHK(oe, 4'h0)
      done("identity");
      for (i = 0; i < 3; i++) begin
         lfsr = lfsr_next(lfsr);
         b = 8'hfe + i[7:0];
         sec_write({2'h1, b}, lfsr[7:0]);
      end
      i_host.frame(8'h48, 24'h0020fe, 24, 1, 8, 24, 1, rd, oe);
      `CHK(rd[23:0], {mem[10'h1fe], mem[10'h1ff], mem[10'h100]})
      for (i = 1; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         sec_write({i[1:0] - 2'h1, lfsr[15:8]}, lfsr[7:0]);
         i_host.frame(8'h48, {8'h00, i[3:0], 4'h0, lfsr[15:8]}, 24, 1, 8, 8, 1, rd, oe);
         `CHK(rd[7:0], lfsr[7:0])
      end
      i_host.frame(8'h48, 24'h0040fe, 24, 1, 8, 8, 1, rd, oe);
      `CHK(rd[7:0], 8'hff)
      done("security");
      @(posedge i_clock);
      busy <= 1'b1;
      repeat (3) @(posedge i_clock);
      `CHK(write_in_progress, 1'b1)
      i_host.frame(8'h9f, 24'h0, 0, 1, 0, 24, 1, rd, oe);
      `CHK(oe, 4'h0)
      i_host.frame(8'hab, 24'h0, 0, 1, 24, 8, 1, rd, oe);
      `CHK(oe, 4'h0)
      @(posedge i_clock);
      busy <= 1'b0;
      repeat (3) @(posedge i_clock);
      `CHK(write_in_progress, 1'b0)
      done("busy");
      i_host.frame(8'hb9, 24'h0, 0, 1, 0, 1, 1, rd, oe);
      repeat (SLP + 20) @(posedge i_clock);
      `CHK(sleep, 1'b0)
      i_host.frame(8'hb9, 24'h0, 0, 1, 0, 0, 1, rd, oe);
      for (i = 0; i < SLP + 10 && sleep !== 1'b1; i++) begin
         @(posedge i_clock);
      end
      `CHK(sleep, 1'b1)
      i_host.frame(8'h4b, 24'h0, 0, 1, 32, 16, 1, rd, oe);
      `CHK(oe, 4'h0)
      i_host.frame(8'hab, 24'h0, 0, 1, 0, 0, 1, rd, oe);
      repeat (WK1 + 10) @(posedge i_clock);
      `CHK(sleep, 1'b0)
      i_host.frame(8'h9f, 24'h0, 0, 1, 0, 8, 1, rd, oe);
      `CHK(rd[7:0], MFR)
      i_host.frame(8'hb9, 24'h0, 0, 1, 0, 0, 1, rd, oe);
      repeat (SLP + 10) @(posedge i_clock);
      i_host.frame(8'hab, 24'h0, 0, 1, 24, 8, 1, rd, oe);
      `CHK(rd[7:0], DEV)
      repeat (WK2 + 10) @(posedge i_clock);
      `CHK(sleep, 1'b0)
      // reset in mid-run while asleep must come back awake
      i_host.frame(8'hb9, 24'h0, 0, 1, 0, 0, 1, rd, oe);
      repeat (SLP + 4) @(posedge i_clock);
      `CHK(sleep, 1'b1)
      resetn <= 1'b0;
      repeat (2) @(posedge i_clock);
      resetn <= 1'b1;
      repeat (4) @(posedge i_clock);
      `CHK(sleep, 1'b0)
      i_host.frame(8'h9f, 24'h0, 0, 1, 0, 8, 1, rd, oe);
      `CHK(rd[7:0], MFR)
      done("power");
      results();
   end
endmodule : tb_flash_id_powerdown_secreg_cmds
